// *** logic/ctpwm_top.v ***
// cascaded 16-bit timer, event counter and pwm with wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "ctpwm_defines.vh"
module ctpwm_top
(
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [4:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // clock sources and power state
  input  wire        fs_tick_i,
  input  wire        low_speed_mode_i,
  // pins
  input  wire        external_count_pin_i,
  output reg         pwm_out_pin_n_o,
  output reg         period_match_irq_o
);
  // registers
  reg  [7:0]  lower_ctl_q;
  reg  [7:0]  upper_ctl_q;
  reg  [7:0]  match_low_byte_q;
  reg  [7:0]  match_high_byte_q;
  reg  [7:0]  compare_low_byte_q;
  reg  [7:0]  compare_high_byte_q;
  reg  [15:0] compare_act_q;
  reg         prescaler_source_sel_q;
  reg  [15:0] count_q;
  reg         out_flop_q;
  reg  [10:0] pre_q;
  reg  [2:0]  fs_pre_q;
  reg         tick_q;

  wire        ext_fall;
  wire        bus_req;
  wire        wr_en;
  wire [2:0]  reg_a;
  wire [2:0]  csel;
  wire        start;
  wire        mode_timer;
  wire        mode_pwm;
  wire        run;
  wire [15:0] match_val;
  wire        at_match;
  wire        at_cmp;
  wire        at_top;
  wire        period_evt;
  wire [7:0]  cnt_lo_nx;
  wire        lo_wrap;

  reg         tick_d;
  reg  [7:0]  rdat;

  ctpwm_sync u_sync
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (external_count_pin_i),
    .fall_o (ext_fall)
  );

  // bus decode: one wait state, ack for one cycle
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_en   = bus_req & we_i & sel_i[0];
  assign reg_a   = adr_i[4:2];

  assign csel  = lower_ctl_q[`CTPWM_F_CSEL];
  assign start = upper_ctl_q[`CTPWM_B_START];
  // 16-bit modes only with both mode fields set
  assign mode_timer = (lower_ctl_q[`CTPWM_F_MODE] == `CTPWM_M_LOW16) &&
                      (upper_ctl_q[`CTPWM_F_MODE] == `CTPWM_M_TIMER);
  assign mode_pwm   = (lower_ctl_q[`CTPWM_F_MODE] == `CTPWM_M_LOW16) &&
                      (upper_ctl_q[`CTPWM_F_MODE] == `CTPWM_M_PWM);
  assign run        = start & (mode_timer | mode_pwm);

  assign match_val = {match_high_byte_q, match_low_byte_q};
  assign at_match  = (count_q == match_val);
  assign at_cmp    = (count_q == compare_act_q);
  assign at_top    = (count_q == `CTPWM_TOP16);
  assign period_evt = run & tick_q & (mode_pwm ? at_top : at_match);

  // lower half and its carry into the upper half
  assign cnt_lo_nx = count_q[7:0] + 8'h01;
  assign lo_wrap   = (count_q[7:0] == 8'hff);

  // source tick selection
  always @*
  begin
    tick_d = 1'b0;
    case (csel)
      `CTPWM_S_DIV11:
        tick_d = prescaler_source_sel_q | low_speed_mode_i ?
                 (fs_tick_i & (fs_pre_q == `CTPWM_FS3)) :
                 (pre_q == `CTPWM_PRE11);
      `CTPWM_S_DIV7:
        tick_d = ~low_speed_mode_i & ((pre_q & `CTPWM_PRE7) == `CTPWM_PRE7);
      `CTPWM_S_DIV5:
        tick_d = ~low_speed_mode_i & ((pre_q & `CTPWM_PRE5) == `CTPWM_PRE5);
      `CTPWM_S_DIV3:
        tick_d = ~low_speed_mode_i & ((pre_q & `CTPWM_PRE3) == `CTPWM_PRE3);
      `CTPWM_S_FS:
        tick_d = mode_pwm & fs_tick_i;
      `CTPWM_S_DIV1:
        tick_d = mode_pwm & ~low_speed_mode_i & ((pre_q & `CTPWM_PRE1) == `CTPWM_PRE1);
      `CTPWM_S_FC:
        tick_d = mode_pwm & ~low_speed_mode_i;
      `CTPWM_S_EXT:
        tick_d = ext_fall;
      default:
        tick_d = 1'b0;
    endcase
  end

  // prescalers run free so the source phase is independent of start
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_q    <= {`CTPWM_PRE_W{1'b0}};
      fs_pre_q <= 3'h0;
      tick_q   <= 1'b0;
    end
    else
    begin
      pre_q  <= pre_q + 11'h001;
      tick_q <= tick_d;
      if (fs_tick_i)
      begin
        fs_pre_q <= fs_pre_q + 3'h1;
      end
    end
  end

  // counter, output flop and period pulse
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_q            <= `CTPWM_RST16;
      out_flop_q         <= 1'b0;
      period_match_irq_o <= 1'b0;
      compare_act_q      <= `CTPWM_RST16;
    end
    else
    begin
      period_match_irq_o <= period_evt;
      if (run & tick_q)
      begin
        if (period_evt)
        begin
          count_q <= `CTPWM_RST16;
        end
        else
        begin
          count_q[7:0] <= cnt_lo_nx;
          if (lo_wrap)
          begin
            count_q[15:8] <= count_q[15:8] + 8'h01;
          end
        end
      end
      // output flop: toggles in pwm, else loaded from the init bit by upper control writes while stopped
      if (wr_en && reg_a == `CTPWM_A_UCTL && !start)
      begin
        out_flop_q <= dat_i[`CTPWM_B_TFF];
      end
      else if (mode_pwm & run & tick_q & (at_top | at_cmp))
      begin
        out_flop_q <= ~out_flop_q;
      end
      // staged compare moves at period end, or follows at once while stopped
      if (!run)
      begin
        compare_act_q <= {compare_high_byte_q, compare_low_byte_q};
      end
      else if (mode_pwm & period_evt)
      begin
        compare_act_q <= {compare_high_byte_q, compare_low_byte_q};
      end
    end
  end

  // pin shows the inverse of the output flop; holds while stopped
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwm_out_pin_n_o <= 1'b1;
    end
    else
    begin
      pwm_out_pin_n_o <= ~out_flop_q;
    end
  end

  // register writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lower_ctl_q            <= `CTPWM_RST8;
      upper_ctl_q            <= `CTPWM_RST8;
      match_low_byte_q       <= `CTPWM_RST8;
      match_high_byte_q      <= `CTPWM_RST8;
      compare_low_byte_q     <= `CTPWM_RST8;
      compare_high_byte_q    <= `CTPWM_RST8;
      prescaler_source_sel_q <= 1'b0;
    end
    else if (wr_en)
    begin
      case (reg_a)
        `CTPWM_A_LCTL: lower_ctl_q <= dat_i[7:0];
        `CTPWM_A_UCTL: upper_ctl_q <= dat_i[7:0];
        `CTPWM_A_MLO:  match_low_byte_q <= dat_i[7:0];
        `CTPWM_A_MHI:  match_high_byte_q <= dat_i[7:0];
        `CTPWM_A_CLO:  compare_low_byte_q <= dat_i[7:0];
        `CTPWM_A_CHI:  compare_high_byte_q <= dat_i[7:0];
        `CTPWM_A_CFG:  prescaler_source_sel_q <= dat_i[`CTPWM_B_PSEL];
        default:       lower_ctl_q <= lower_ctl_q;
      endcase
    end
  end

  // read mux: running pwm shows the active compare, not the staged one
  always @*
  begin
    rdat = `CTPWM_RST8;
    case (reg_a)
      `CTPWM_A_LCTL: rdat = lower_ctl_q;
      `CTPWM_A_UCTL: rdat = upper_ctl_q;
      `CTPWM_A_MLO:  rdat = match_low_byte_q;
      `CTPWM_A_MHI:  rdat = match_high_byte_q;
      `CTPWM_A_CLO:  rdat = compare_act_q[7:0];
      `CTPWM_A_CHI:  rdat = compare_act_q[15:8];
      `CTPWM_A_CFG:  rdat = {7'h00, prescaler_source_sel_q};
      default:       rdat = `CTPWM_RST8;
    endcase
  end

  // bus answer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= `CTPWM_RST32;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_req && reg_a == `CTPWM_A_CNT)
      begin
        dat_o <= {16'h0000, count_q};
      end
      else if (bus_req)
      begin
        dat_o <= {24'h000000, rdat};
      end
    end
  end
endmodule // ctpwm_top

// *** logic/ctpwm_defines.vh ***
// constants for the cascaded 16-bit timer / pwm block
// Summary of operation
// - timer mode joins both 8-bit counters into one 16-bit counter on prescaled ticks.
// - once started, counter equal to match raises period pulse, clears, keeps counting.
// - match register takes effect at once; software must not change it while running.
// - timer source is one of four prescaled clocks, first picked by prescaler source select.
// - event counter mode counts falling edges of the external count pin.
// - count pin levels must last two cycles; external source rate is limited.
// - pwm toggles flop on compare equality, toggles again on overflow, clears, pulses.
// - pwm counter may use internal prescaled clock or external count pin.
// - output flop loads from init bit; reset clears it to 0.
// - pwm pin is driven with the inverse of the output flop.
// - pwm compare is double buffered; moves at period pulse, at once when stopped.
// - running pwm compare reads return active value until next period pulse.
// - stopping holds the pin; only a later init bit write changes its level.
// - pwm mode adds low freq clock, high freq clock / 2 and high freq clock sources.
// - clearing upper control bit 3 stops; clearing bit 7 while stopped clears flop, pin high.
`ifndef CTPWM_DEFINES_VH
`define CTPWM_DEFINES_VH
// register byte offsets, address bits 4:2
`define CTPWM_A_LCTL     3'h0
`define CTPWM_A_UCTL     3'h1
`define CTPWM_A_MLO      3'h2
`define CTPWM_A_MHI      3'h3
`define CTPWM_A_CLO      3'h4
`define CTPWM_A_CHI      3'h5
`define CTPWM_A_CFG      3'h6
`define CTPWM_A_CNT      3'h7
// control fields
`define CTPWM_B_START    3
`define CTPWM_B_TFF      7
`define CTPWM_F_MODE     2:0
`define CTPWM_F_CSEL     6:4
`define CTPWM_B_PSEL     0
// mode codes
`define CTPWM_M_LOW16    3'h3
`define CTPWM_M_TIMER    3'h4
`define CTPWM_M_PWM      3'h6
// source select codes
`define CTPWM_S_DIV11    3'h0
`define CTPWM_S_DIV7     3'h1
`define CTPWM_S_DIV5     3'h2
`define CTPWM_S_DIV3     3'h3
`define CTPWM_S_FS       3'h4
`define CTPWM_S_DIV1     3'h5
`define CTPWM_S_FC       3'h6
`define CTPWM_S_EXT      3'h7
// prescaler taps
`define CTPWM_PRE_W      11
`define CTPWM_PRE11      11'h7ff
`define CTPWM_PRE7       11'h07f
`define CTPWM_PRE5       11'h01f
`define CTPWM_PRE3       11'h007
`define CTPWM_PRE1       11'h001
`define CTPWM_FS3        3'h7
// reset values and the 16-bit counter top
`define CTPWM_RST8       8'h00
`define CTPWM_RST16      16'h0000
`define CTPWM_TOP16      16'hffff
`define CTPWM_RST32      32'h0000_0000
`endif

// *** logic/ctpwm_sync.v ***
// two-flop synchroniser with falling edge detect for the count pin
`timescale 1ns/10ps
module ctpwm_sync
(
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // pin and event
  input  wire pin_i,
  output reg  fall_o
);
  reg meta_q;
  reg sync_q;
  reg last_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
      fall_o <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
      fall_o <= last_q & ~sync_q;
    end
  end
endmodule // ctpwm_sync

// *** dv/ctpwm_properties.sv ***
// port assertions for the cascaded timer and pwm block
`timescale 1ns/10ps
module ctpwm_properties
(
  // clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // wishbone
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [4:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // pins
  input wire        pwm_out_pin_n_o,
  input wire        period_match_irq_o
);
  wire      req_w = cyc_i & stb_i & ~ack_o;
  wire      wr_u  = req_w & we_i & sel_i[0] & (adr_i[4:2] == 3'h1);
  reg       run_q;
  reg [1:0] idle_q;
  // mirror of the start bit, and quiet cycles since stopping
  always @(posedge clk_i)
    if (rst_i)
      run_q <= 1'b0;
    else if (wr_u)
      run_q <= dat_i[3];
  always @(posedge clk_i)
    if (rst_i | run_q | wr_u)
      idle_q <= 2'h0;
    else if (idle_q != 2'h3)
      idle_q <= idle_q + 2'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; req_w |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; ack_o |-> $past(cyc_i & stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_rst_pin; $fell(rst_i) |-> pwm_out_pin_n_o && !period_match_irq_o; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin or irq wrong after reset");
  property p_init_load; wr_u && !run_q |-> ##2 pwm_out_pin_n_o == !$past(dat_i[7], 2); endproperty
  a_init_load: assert property (p_init_load) else $error("pin not loaded from init");
  property p_stop_hold; idle_q == 2'h3 |-> $stable(pwm_out_pin_n_o); endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("pin moved while stopped");
  property p_stop_irq; idle_q == 2'h3 |-> !period_match_irq_o; endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("irq while stopped");
  property p_irq_pulse; period_match_irq_o |=> !period_match_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");
endmodule // ctpwm_properties

// *** dv/tb_top.sv ***
// self-checking bench for the cascaded timer and pwm block
`timescale 1ns/10ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        fs_tick_i = 1'b0;
  logic        low_speed_mode_i = 1'b0;
  logic        external_count_pin_i = 1'b1;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire         pwm_out_pin_n_o;
  wire         period_match_irq_o;
  int          failures = 0;
  int          checks = 0;
  int          irqs = 0;
  int          i0;
  time         t0;
  logic [31:0] q;
  logic [31:0] q0;
  logic [1:0]  fsd = 2'h0;
  // {expected ticks, mode, low speed, cfg, source}
  logic [31:0] tab [0:8] = '{32'h0001_4000, 32'h0040_4010, 32'h0040_4100, 32'h0010_4001,
    32'h0040_4002, 32'h0100_4003, 32'h0200_6004, 32'h0400_6005, 32'h0800_6006};
  ctpwm_top DUT
  (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .cyc_i                (cyc_i),
    .stb_i                (stb_i),
    .we_i                 (we_i),
    .adr_i                (adr_i),
    .sel_i                (sel_i),
    .dat_i                (dat_i),
    .dat_o                (dat_o),
    .ack_o                (ack_o),
    .fs_tick_i            (fs_tick_i),
    .low_speed_mode_i     (low_speed_mode_i),
    .external_count_pin_i (external_count_pin_i),
    .pwm_out_pin_n_o      (pwm_out_pin_n_o),
    .period_match_irq_o   (period_match_irq_o)
  );
  always #50 clk_i = ~clk_i;
  // low freq tick every 4 cycles, irq pulse counter
  always @(posedge clk_i)
  begin
    fsd <= fsd + 2'h1;
    fs_tick_i <= (fsd == 2'h3);
    if (period_match_irq_o)
      irqs <= irqs + 1;
  end
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pin(input logic e);
    chk("pin", {15'h0, pwm_out_pin_n_o}, {15'h0, e});
  endtask
  task automatic bus(input logic w, input logic [2:0] r, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {r, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    @(posedge clk_i iff ack_o);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    bus(1'b1, a, v[7:0]);
    bus(1'b1, a + 3'h1, v[15:8]);
  endtask
  task automatic rst(input int n);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic falls(input int n);
    repeat (n)
    begin
      external_count_pin_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      external_count_pin_i <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask
  initial
  begin
    #(95000 * 100);
    failures++;
    end_sim;
  end
  initial
  begin
    rst(10);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, i[2:0], 8'h00);
      chk("reset reg", q[15:0], 16'h0000);
    end
    pin(1'b1);
    $display("reset test done");
    wr16(3'h2, 16'h0004);
    bus(1'b1, 3'h0, 8'h33);
    bus(1'b1, 3'h1, 8'h0c);
    @(posedge clk_i iff period_match_irq_o);
    t0 = $time;
    @(posedge clk_i iff period_match_irq_o);
    chk("timer period", 16'(($time - t0) / 100), 16'h0028);
    $display("timer test done");
    rst(2);
    wr16(3'h2, 16'h0002);
    bus(1'b1, 3'h0, 8'h73);
    bus(1'b1, 3'h1, 8'h0c);
    i0 = irqs;
    falls(8);
    chk("event irqs", 16'(irqs - i0), 16'h0002);
    bus(1'b0, 3'h7, 8'h00);
    chk("event count", q[15:0], 16'h0002);
    rst(2);
    bus(1'b1, 3'h0, 8'h73);
    bus(1'b1, 3'h1, 8'h0e);
    falls(5);
    bus(1'b0, 3'h7, 8'h00);
    chk("pwm ext count", q[15:0], 16'h0005);
    $display("event test done");
    rst(2);
    wr16(3'h2, 16'hffff);
    for (int i = 0; i < 9; i++)
    begin
      low_speed_mode_i <= tab[i][8];
      bus(1'b1, 3'h6, {7'h0, tab[i][4]});
      bus(1'b1, 3'h0, {1'b0, tab[i][2:0], 4'h3});
      bus(1'b1, 3'h1, {4'h0, 1'b1, tab[i][14:12]});
      bus(1'b0, 3'h7, 8'h00);
      q0 = q;
      repeat (2045) @(posedge clk_i);
      bus(1'b0, 3'h7, 8'h00);
      chk("tick rate", q[15:0] - q0[15:0], tab[i][31:16]);
      bus(1'b1, 3'h1, {5'h0, tab[i][14:12]});
    end
    $display("source test done");
    // counter is held across stops, so clear it for a known pwm phase
    rst(2);
    bus(1'b1, 3'h0, 8'h63);
    wr16(3'h4, 16'h0010);
    bus(1'b1, 3'h1, 8'h86);
    pin(1'b0);
    bus(1'b1, 3'h1, 8'h8e);
    wr16(3'h4, 16'h0020);
    bus(1'b0, 3'h4, 8'h00);
    chk("staged read", q[15:0], 16'h0010);
    repeat (8) @(posedge clk_i);
    pin(1'b1);
    @(posedge clk_i iff period_match_irq_o);
    repeat (2) @(posedge clk_i);
    pin(1'b0);
    repeat (16) @(posedge clk_i);
    pin(1'b0);
    repeat (30) @(posedge clk_i);
    pin(1'b1);
    bus(1'b0, 3'h4, 8'h00);
    chk("active read", q[15:0], 16'h0020);
    bus(1'b1, 3'h1, 8'h86);
    repeat (20) @(posedge clk_i);
    pin(1'b1);
    bus(1'b1, 3'h1, 8'h86);
    pin(1'b0);
    bus(1'b1, 3'h1, 8'h06);
    pin(1'b1);
    $display("pwm test done");
    end_sim;
  end
endmodule // tb_top
bind ctpwm_top ctpwm_properties u_chk
(
  .clk_i              (clk_i),
  .rst_i              (rst_i),
  .cyc_i              (cyc_i),
  .stb_i              (stb_i),
  .we_i               (we_i),
  .adr_i              (adr_i),
  .sel_i              (sel_i),
  .dat_i              (dat_i),
  .ack_o              (ack_o),
  .pwm_out_pin_n_o    (pwm_out_pin_n_o),
  .period_match_irq_o (period_match_irq_o)
);
